/* bwc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Host issuing commands and the correction engine's flags.
module bwc_host_model #(
    parameter int ADDR_W = 24
) (
    input  wire logic         ref_clk,
    input  wire logic         cmd_ready,
    input  wire logic         rsp_valid,
    input  wire logic [7:0]   rsp_data,
    input  wire logic         ecc_lookup,
    input  wire logic [2:0]   ecc_flags,
    output logic              cmd_valid,
    output logic [7:0]        cmd_op,
    output logic [ADDR_W-1:0] cmd_addr,
    output logic [7:0]        cmd_wdata,
    output logic              ecc_code_err,
    output logic              ecc_data_err,
    output logic              ecc_off
);
    logic       rdy_s;   // Ready as sampled at the edge.
    logic       rsp_s;   // Answer strobe as sampled at the edge.
    logic [7:0] data_s;  // Answer byte as sampled at the edge.

    // Quiet port at time zero.
    initial begin
        cmd_valid = 1'b0;
        cmd_op    = 8'h00;
        cmd_addr  = '0;
        cmd_wdata = 8'h00;
        {ecc_code_err, ecc_data_err, ecc_off} = 3'h0;
    end

    // Samples the handshake at the edge.
    always @(posedge ref_clk) begin
        rdy_s  <= cmd_ready;
        rsp_s  <= rsp_valid;
        data_s <= rsp_data;
    end

    // Flags are valid only in the lookup cycle; elsewhere they toggle.
    always @(posedge ref_clk) begin
        #1;
        {ecc_code_err, ecc_data_err, ecc_off} <= ecc_lookup ? ecc_flags :
            ~{ecc_code_err, ecc_data_err, ecc_off};
    end

    // Holds one command until taken, then waits for the answer of a read (0x65, 0x18, 0x19) only.
    task automatic send(input logic [7:0] op, input logic [ADDR_W-1:0] a,
                        input logic [7:0] d, output logic [7:0] r, output bit to);
        to        = 1'b1;
        r         = 8'h00;
        cmd_op    = op;
        cmd_addr  = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        for (int n = 0; n < 16 && to; n++) begin
            @(posedge ref_clk);
            #1;
            to = !rdy_s;
        end
        // Released lines show the inverse.
        cmd_valid = 1'b0;
        cmd_op    = ~op;
        cmd_addr  = ~a;
        cmd_wdata = ~d;
        if (!to && (op == 8'h65 || op == 8'h18 || op == 8'h19)) begin
            to = 1'b1;
            for (int n = 0; n < 8 && to; n++) begin
                @(posedge ref_clk);
                #1;
                to = !rsp_s;
            end
            r = data_s;
        end else begin
            @(posedge ref_clk);
            #1;
        end
    endtask
endmodule // bwc_host_model

`default_nettype wire

/* bwc_map.svh */
// Operation
// R1 - Wrap applies to main array reads only
// R2 - Resets copy boot register into live register
// R3 - Generic read and write reach both registers
// R4 - Burst length set writes live copy only
// R5 - Bit 4 low enables wrap, boots sequential
// R6 - Wrap affects quad and DDR quad reads
// R7 - Bits 1:0 select 8/16/32/64 byte wrap
// R8 - Bits 7:5 select drive strength, default 000
// R9 - Status read takes unit address, returns byte
// R10 - Bit 2 flags corrected code word error
// R11 - Bit 1 flags corrected data error
// R12 - Bit 0 flags correction disabled
// R13 - Status register is hardware-set and read-only
// R14 - Status bits 7:3 reserved, host ignores them
// R15 - Wrapped burst returns to aligned block start
`ifndef BWC_MAP_SVH
`define BWC_MAP_SVH

// Command operation codes seen on the command port.
`define BWC_OP_GEN_REG_READ   8'h65
`define BWC_OP_GEN_REG_WRITE  8'h71
`define BWC_OP_BURST_LEN_SET  8'hc0
`define BWC_OP_CORR_READ_A    8'h18
`define BWC_OP_CORR_READ_B    8'h19

// Register addresses used by the generic register commands.
`define BWC_ADDR_WRAP_BOOT    32'h0000_0005
`define BWC_ADDR_WRAP_LIVE    32'h0080_0005

// Field positions inside both wrap configuration registers.
`define BWC_WRAP_OFF_BIT      4
`define BWC_LEN_LSB           0
`define BWC_LEN_MSB           1
`define BWC_DRIVE_LSB         5
`define BWC_DRIVE_MSB         7

// Writable bits (reserved bits 3:2 stay zero) and the boot default.
`define BWC_WRITE_MASK        8'hf3
`define BWC_BOOT_RESET        8'h10

// Field positions inside the correction status byte.
`define BWC_STAT_CODE_BIT     2
`define BWC_STAT_DATA_BIT     1
`define BWC_STAT_OFF_BIT      0

// Width of the in-block offset counter for the longest wrap.
`define BWC_WRAP_OFS_W        6

`endif

/* bwc_pkg.sv */
package bwc_pkg;

    // Kind of read command that opens a burst.
    typedef enum logic [1:0] {
        BWC_RD_PLAIN,
        BWC_RD_QUAD_IO,
        BWC_RD_DDR_QUAD_IO
    } bwc_rd_kind_e;

    // Area of the device that a read targets.
    typedef enum logic [1:0] {
        BWC_TGT_MAIN,
        BWC_TGT_REGISTER,
        BWC_TGT_OTP
    } bwc_rd_target_e;

    // Command sequencer states.
    typedef enum logic [1:0] {
        BWC_ST_IDLE,
        BWC_ST_LOOKUP,
        BWC_ST_ANSWER
    } bwc_state_e;

endpackage

/* bwc_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "bwc_map.svh"

// Self-checking bench for the wrap and status logic.
module tb;
    import bwc_pkg::*;
    localparam int ADDR_W = 24;
    localparam logic [ADDR_W-1:0] BOOT_A = ADDR_W'(`BWC_ADDR_WRAP_BOOT);
    localparam logic [ADDR_W-1:0] LIVE_A = ADDR_W'(`BWC_ADDR_WRAP_LIVE);

    logic ref_clk = 1'b0, rst_b = 1'b0, hw_reset_pin_b = 1'b1, sw_reset = 1'b0;
    logic cmd_valid, cmd_ready, rsp_valid, ecc_lookup, ecc_code_err, ecc_data_err, ecc_off;
    logic [7:0] cmd_op, cmd_wdata, rsp_data;
    logic [ADDR_W-1:0] cmd_addr, ecc_unit_addr, rd_addr_out;
    logic [ADDR_W-1:0] rd_addr = '0;
    logic rd_start = 1'b0, rd_next = 1'b0, rd_wrapping, wrap_off;
    bwc_rd_kind_e rd_kind = BWC_RD_PLAIN;
    bwc_rd_target_e rd_target = BWC_TGT_MAIN;
    logic [2:0] drive_strength_sel, ecc_flags = 3'h0;
    logic [1:0] wrap_length_live;
    wire logic [7:0] fields = {drive_strength_sel, wrap_off, 2'b00, wrap_length_live};
    int fail_count = 0;
    int cmp_count = 0;

    bwc_top #(.ADDR_W(ADDR_W)) i_bwc_top (.ref_clk, .rst_b, .hw_reset_pin_b, .sw_reset,
        .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_data,
        .ecc_lookup, .ecc_unit_addr, .ecc_code_err, .ecc_data_err, .ecc_off, .rd_start,
        .rd_kind, .rd_target, .rd_addr, .rd_next, .rd_addr_out, .rd_wrapping,
        .drive_strength_sel, .wrap_off, .wrap_length_live);
    bwc_host_model #(.ADDR_W(ADDR_W)) i_host (.ref_clk, .cmd_ready, .rsp_valid, .rsp_data,
        .ecc_lookup, .ecc_flags, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata, .ecc_code_err,
        .ecc_data_err, .ecc_off);

    always #2.5 ref_clk = ~ref_clk;

    // Compares one byte result.
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compares one address result.
    task automatic check_addr(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict;
        $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Issues one command; a command never taken ends the run.
    task automatic cmd(input logic [7:0] op, input logic [ADDR_W-1:0] a,
                       input logic [7:0] d, output logic [7:0] r);
        bit to;
        i_host.send(op, a, d, r, to);
        if (to) begin
            fail_count++;
            give_verdict();
        end
    endtask

    // Boot defaults: sequential, 8 bytes, drive 000.
    task automatic t_defaults;
        logic [7:0] r;
        cmd(8'h65, BOOT_A, 8'h00, r);
        check_byte(r, 8'h10);
        cmd(8'h65, LIVE_A, 8'h00, r);
        check_byte(r, 8'h10);
        check_byte(fields, 8'h10);
    endtask

    // Generic access reaches both copies only.
    task automatic t_access;
        logic [7:0] r;
        cmd(8'h71, LIVE_A, 8'hff, r);
        check_byte(fields, 8'hf3);
        cmd(8'h71, BOOT_A, 8'he2, r);
        cmd(8'h65, BOOT_A, 8'h00, r);
        check_byte(r, 8'he2);
        cmd(8'h71, 24'h000042, 8'h5a, r);
        cmd(8'h65, 24'h000042, 8'h00, r);
        check_byte(r, 8'h00);
        cmd(8'h65, LIVE_A, 8'h00, r);
        check_byte(r, 8'hf3);
    endtask

    // Burst length set spares boot; resets reload from it.
    task automatic t_reload;
        logic [7:0] r;
        cmd(8'hc0, '0, 8'h21, r);
        check_byte(fields, 8'h21);
        cmd(8'h65, BOOT_A, 8'h00, r);
        check_byte(r, 8'he2);
        sw_reset = 1'b1;
        @(posedge ref_clk);
        #1 sw_reset = 1'b0;
        check_byte(fields, 8'he2);
        cmd(8'hc0, '0, 8'h00, r);
        hw_reset_pin_b = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1 hw_reset_pin_b = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1 check_byte(fields, 8'he2);
    endtask

    // Every flag combination, back to back; reserved bits ignored.
    task automatic t_status;
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            ecc_flags = i[2:0];
            cmd(i[0] ? 8'h19 : 8'h18, ADDR_W'(i * 16), 8'h00, r);
            check_byte(r & 8'h07, {5'h00, i[2:0]});
            check_addr(ecc_unit_addr, ADDR_W'(i * 16));
        end
    endtask

    // Walks one burst from near a block end.
    task automatic burst(input bwc_rd_kind_e k, input bwc_rd_target_e t,
                         input logic [1:0] len, input logic wrap);
        logic [ADDR_W-1:0] e, m;
        m = ADDR_W'((8 << len) - 1);
        e = ADDR_W'(24'h01203d);
        rd_kind = k;
        rd_target = t;
        rd_addr = e;
        rd_start = 1'b1;
        @(posedge ref_clk);
        #1 rd_start = 1'b0;
        rd_next = 1'b1;
        check_addr(rd_addr_out, e);
        check_byte({7'h00, rd_wrapping}, {7'h00, wrap});
        for (int n = 0; n < 12; n++) begin
            @(posedge ref_clk);
            #1 e = wrap ? ((e & ~m) | ((e + 1'b1) & m)) : e + 1'b1;
            check_addr(rd_addr_out, e);
        end
        rd_next = 1'b0;
    endtask

    // Quad main reads wrap at each length; others stay sequential.
    task automatic t_wrap;
        logic [7:0] r;
        for (int l = 0; l < 4; l++) begin
            cmd(8'h71, LIVE_A, {6'h00, l[1:0]}, r);
            burst(BWC_RD_QUAD_IO, BWC_TGT_MAIN, l[1:0], 1'b1);
        end
        burst(BWC_RD_DDR_QUAD_IO, BWC_TGT_MAIN, 2'h3, 1'b1);
        burst(BWC_RD_PLAIN, BWC_TGT_MAIN, 2'h3, 1'b0);
        burst(BWC_RD_QUAD_IO, BWC_TGT_REGISTER, 2'h3, 1'b0);
        burst(BWC_RD_QUAD_IO, BWC_TGT_OTP, 2'h3, 1'b0);
        cmd(8'hc0, '0, 8'h13, r);
        burst(BWC_RD_QUAD_IO, BWC_TGT_MAIN, 2'h3, 1'b0);
    endtask

    // Reset, then the scenarios in order.
    initial begin
        repeat (16) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        t_defaults();
        t_access();
        t_reload();
        t_status();
        t_wrap();
        give_verdict();
    end
endmodule // tb

`default_nettype wire

/* bwc_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "bwc_map.svh"

// Burst wrap configuration and correction status logic of the flash.
module bwc_top #(
    parameter int ADDR_W = 24
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    input  wire logic                     hw_reset_pin_b,
    input  wire logic                     sw_reset,
    input  wire logic                     cmd_valid,
    output logic                          cmd_ready,
    input  wire logic [7:0]               cmd_op,
    input  wire logic [ADDR_W-1:0]        cmd_addr,
    input  wire logic [7:0]               cmd_wdata,
    output logic                          rsp_valid,
    output logic [7:0]                    rsp_data,
    output logic                          ecc_lookup,
    output logic [ADDR_W-1:0]             ecc_unit_addr,
    input  wire logic                     ecc_code_err,
    input  wire logic                     ecc_data_err,
    input  wire logic                     ecc_off,
    input  wire logic                     rd_start,
    input  wire bwc_pkg::bwc_rd_kind_e    rd_kind,
    input  wire bwc_pkg::bwc_rd_target_e  rd_target,
    input  wire logic [ADDR_W-1:0]        rd_addr,
    input  wire logic                     rd_next,
    output logic [ADDR_W-1:0]             rd_addr_out,
    output logic                          rd_wrapping,
    output logic [2:0]                    drive_strength_sel,
    output logic                          wrap_off,
    output logic [1:0]                    wrap_length_live
);
    import bwc_pkg::*;

    // The register addresses need at least this many address bits.
    if (ADDR_W < 24) begin : g_chk
        $error("bwc_top: ADDR_W must be at least 24");
    end

    // True when the address selects the boot copy.
    function automatic logic is_boot_addr(input logic [ADDR_W-1:0] a);
        return a == ADDR_W'(`BWC_ADDR_WRAP_BOOT);
    endfunction

    // True when the address selects the live copy.
    function automatic logic is_live_addr(input logic [ADDR_W-1:0] a);
        return a == ADDR_W'(`BWC_ADDR_WRAP_LIVE);
    endfunction

    // True for either correction status read code.
    function automatic logic is_corr_read(input logic [7:0] op);
        return (op == `BWC_OP_CORR_READ_A) || (op == `BWC_OP_CORR_READ_B);
    endfunction

    // True when a read qualifies for wrapping by kind and target.
    function automatic logic wrap_eligible(input bwc_rd_kind_e k,
                                           input bwc_rd_target_e t);
        logic quad;
        quad = (k == BWC_RD_QUAD_IO) || (k == BWC_RD_DDR_QUAD_IO); // R6
        return quad && (t == BWC_TGT_MAIN); // R1
    endfunction

    logic hw_s1_q, hw_s2_q, hw_s3_q;  // Three-stage pin synchroniser.
    logic hw_lvl_q, hw_lvl_d;         // Accepted pin level.

    // Accepts a new pin level only once the last two stages agree.
    always_comb begin
        hw_lvl_d = hw_lvl_q;
        if (hw_s2_q == hw_s3_q) begin
            hw_lvl_d = hw_s3_q;
        end
    end

    // Registers the synchroniser chain and the accepted level.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            hw_s1_q  <= 1'b1;
            hw_s2_q  <= 1'b1;
            hw_s3_q  <= 1'b1;
            hw_lvl_q <= 1'b1;
        end else begin
            hw_s1_q  <= hw_reset_pin_b;
            hw_s2_q  <= hw_s1_q;
            hw_s3_q  <= hw_s2_q;
            hw_lvl_q <= hw_lvl_d;
        end
    end

    // A held pin or a software reset keeps reloading the live copy.
    logic reload;
    assign reload = !hw_lvl_q || sw_reset;

    bwc_state_e        st_q, st_d;          // Sequencer state.
    logic [7:0]        boot_q, boot_d;      // Boot copy of wrap config.
    logic [7:0]        live_q, live_d;      // Live copy of wrap config.
    logic              rsp_v_q, rsp_v_d;    // Answer strobe.
    logic [7:0]        rsp_q, rsp_d;        // Answer byte.
    logic [ADDR_W-1:0] unit_q, unit_d;      // Selected correction unit.
    logic [7:0]        stat_q, stat_d;      // Captured correction status.
    logic              take;                // A command is accepted.

    // Commands are refused only while a status read is in flight.
    assign cmd_ready = (st_q == BWC_ST_IDLE);
    assign take      = cmd_valid && cmd_ready;

    // Computes the next configuration, status and answer values.
    always_comb begin
        st_d    = st_q;
        boot_d  = boot_q;
        live_d  = live_q;
        rsp_v_d = 1'b0;
        rsp_d   = rsp_q;
        unit_d  = unit_q;
        stat_d  = stat_q;
        case (st_q)
            BWC_ST_IDLE: begin
                if (take) begin
                    // Generic read returns the addressed copy next cycle.
                    if (cmd_op == `BWC_OP_GEN_REG_READ) begin
                        rsp_v_d = 1'b1;
                        if (is_boot_addr(cmd_addr)) begin
                            rsp_d = boot_q; // R3
                        end else if (is_live_addr(cmd_addr)) begin
                            rsp_d = live_q; // R3
                        end else begin
                            // Unmapped addresses read as zero.
                            rsp_d = 8'h00;
                        end
                    end else if (cmd_op == `BWC_OP_GEN_REG_WRITE) begin
                        // Generic write reaches either copy; reserved bits stay zero.
                        if (is_boot_addr(cmd_addr)) begin
                            boot_d = cmd_wdata & `BWC_WRITE_MASK; // R3
                        end else if (is_live_addr(cmd_addr)) begin
                            live_d = cmd_wdata & `BWC_WRITE_MASK; // R3
                        end
                        // Any other address is ignored.
                    end else if (cmd_op == `BWC_OP_BURST_LEN_SET) begin
                        // Only the live copy is touched; the boot copy holds.
                        live_d = cmd_wdata & `BWC_WRITE_MASK; // R4
                    end else if (is_corr_read(cmd_op)) begin
                        // The unit address comes with the command.
                        unit_d = cmd_addr; // R9
                        st_d   = BWC_ST_LOOKUP;
                    end
                end
            end
            BWC_ST_LOOKUP: begin
                // The correction engine answers during the lookup cycle.
                stat_d = 8'h00; // R14
                stat_d[`BWC_STAT_CODE_BIT] = ecc_code_err; // R10
                stat_d[`BWC_STAT_DATA_BIT] = ecc_data_err; // R11
                stat_d[`BWC_STAT_OFF_BIT]  = ecc_off; // R12
                st_d = BWC_ST_ANSWER;
            end
            BWC_ST_ANSWER: begin
                // The status byte is only ever filled from hardware flags.
                rsp_v_d = 1'b1; // R13
                rsp_d   = stat_q; // R9
                st_d    = BWC_ST_IDLE;
            end
            default: begin
                st_d = BWC_ST_IDLE;
            end
        endcase
        // A reset reload outranks any live copy write in the same cycle.
        if (reload) begin
            live_d = boot_q; // R2
        end
    end

    // Registers the sequencer, configuration and answer.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_q    <= BWC_ST_IDLE;
            // Power-on leaves both copies at the boot default.
            boot_q  <= `BWC_BOOT_RESET; // R5
            live_q  <= `BWC_BOOT_RESET; // R2
            rsp_v_q <= 1'b0;
            rsp_q   <= 8'h00;
            unit_q  <= '0;
            stat_q  <= 8'h00;
        end else begin
            st_q    <= st_d;
            boot_q  <= boot_d;
            live_q  <= live_d;
            rsp_v_q <= rsp_v_d;
            rsp_q   <= rsp_d;
            unit_q  <= unit_d;
            stat_q  <= stat_d;
        end
    end

    // Answer and unit address outputs come from flip-flops; lookup is decoded from the state.
    assign rsp_valid     = rsp_v_q;
    assign rsp_data      = rsp_q;
    assign ecc_lookup    = (st_q == BWC_ST_LOOKUP);
    assign ecc_unit_addr = unit_q;

    // Drive strength follows the live copy.
    assign drive_strength_sel = live_q[`BWC_DRIVE_MSB:`BWC_DRIVE_LSB]; // R8
    // Active-low wrap enable: one means sequential.
    assign wrap_off           = live_q[`BWC_WRAP_OFF_BIT]; // R5
    // Length code picks 8, 16, 32 or 64 bytes.
    assign wrap_length_live   = live_q[`BWC_LEN_MSB:`BWC_LEN_LSB]; // R7

    bwc_wrap_if #(.ADDR_W(ADDR_W)) wrp ();

    // Wrap only for quad reads of the main array with wrap enabled.
    assign wrp.start    = rd_start;
    assign wrp.base     = rd_addr;
    assign wrp.enable   = wrap_eligible(rd_kind, rd_target) && !wrap_off; // R5
    assign wrp.len_code = wrap_length_live; // R7
    assign wrp.advance  = rd_next;

    bwc_wrap_gen #(
        .ADDR_W (ADDR_W)
    ) u_gen (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .wrp     (wrp)
    );

    assign rd_addr_out = wrp.addr;
    assign rd_wrapping = wrp.wrapping;

endmodule // bwc_top

`default_nettype wire

/* bwc_top_chk.sv */
`timescale 1ns/100ps
`default_nettype none
`include "bwc_map.svh"

// Watches the top ports for command, reload and burst behaviour.
module bwc_top_chk
    import bwc_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    input wire logic              ref_clk,
    input wire logic              rst_b,
    input wire logic              sw_reset,
    input wire logic              cmd_valid,
    input wire logic              cmd_ready,
    input wire logic [7:0]        cmd_op,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [7:0]        cmd_wdata,
    input wire logic              rsp_valid,
    input wire logic [7:0]        rsp_data,
    input wire logic              ecc_lookup,
    input wire logic [ADDR_W-1:0] ecc_unit_addr,
    input wire logic              ecc_code_err,
    input wire logic              ecc_data_err,
    input wire logic              ecc_off,
    input wire logic              rd_start,
    input wire bwc_rd_kind_e      rd_kind,
    input wire bwc_rd_target_e    rd_target,
    input wire logic [ADDR_W-1:0] rd_addr,
    input wire logic              rd_next,
    input wire logic [ADDR_W-1:0] rd_addr_out,
    input wire logic              rd_wrapping,
    input wire logic [2:0]        drive_strength_sel,
    input wire logic              wrap_off,
    input wire logic [1:0]        wrap_length_live
);
    localparam logic [ADDR_W-1:0] BOOT_A = ADDR_W'(`BWC_ADDR_WRAP_BOOT);
    localparam logic [ADDR_W-1:0] LIVE_A = ADDR_W'(`BWC_ADDR_WRAP_LIVE);

    logic [7:0]        boot_q, boot_d;  // Shadow of the boot copy.
    logic [1:0]        len_q, len_d;    // Wrap length in force for the open burst.
    logic [ADDR_W-1:0] mask_w;          // Offset mask of the open burst.
    logic              take_w;          // A command is taken this cycle.
    logic [7:0]        live_w;          // Live fields packed as a register byte.

    assign take_w = cmd_valid && cmd_ready;
    assign mask_w = ADDR_W'((8 << len_q) - 1);
    assign live_w = {drive_strength_sel, wrap_off, 2'b00, wrap_length_live};

    // Follows boot writes and latches the length at each burst start.
    always_comb begin
        boot_d = boot_q;
        len_d  = rd_start ? wrap_length_live : len_q;
        if (!rst_b) begin
            boot_d = `BWC_BOOT_RESET;
        end else if (take_w && cmd_op == 8'h71 && cmd_addr == BOOT_A) begin
            boot_d = cmd_wdata & `BWC_WRITE_MASK;
        end
    end

    // Registers the shadow state.
    always_ff @(posedge ref_clk) begin
        boot_q <= boot_d;
        len_q  <= len_d;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // A status read is taken.
    sequence stat_take;
        take_w && (cmd_op == 8'h18 || cmd_op == 8'h19);
    endsequence
    // Lookup, one more busy cycle, then the answer.
    sequence stat_answer;
        ecc_lookup && !cmd_ready ##1 !cmd_ready && !rsp_valid ##1 rsp_valid;
    endsequence

    read_pulse_a: assert property (take_w && cmd_op == 8'h65 |=> rsp_valid ##1 !rsp_valid)
        else $error("read answer not one pulse");
    boot_read_a: assert property (take_w && cmd_op == 8'h65 && cmd_addr == BOOT_A |=> rsp_data == boot_q)
        else $error("boot copy read wrong");
    stat_seq_a: assert property (stat_take |=> ecc_unit_addr == $past(cmd_addr) ##0 stat_answer)
        else $error("status read sequence broken");
    stat_byte_a: assert property (ecc_lookup |=> ##1 rsp_data[2:0] ==
        {$past(ecc_code_err, 2), $past(ecc_data_err, 2), $past(ecc_off, 2)})
        else $error("status byte wrong");
    live_write_a: assert property (take_w && !sw_reset &&
        (cmd_op == 8'hc0 || (cmd_op == 8'h71 && cmd_addr == LIVE_A)) |=>
        live_w == ($past(cmd_wdata) & 8'hf3))
        else $error("live copy write not applied");
    sw_reload_a: assert property (sw_reset |=> live_w == $past(boot_q))
        else $error("software reset reload missing");
    burst_start_a: assert property (rd_start |=> rd_addr_out == $past(rd_addr) &&
        rd_wrapping == (!$past(wrap_off) && $past(rd_target) == BWC_TGT_MAIN &&
        $past(rd_kind) != BWC_RD_PLAIN))
        else $error("burst start wrong");
    wrap_step_a: assert property (rd_next && !rd_start |=> rd_addr_out ==
        ($past(rd_wrapping) ? (($past(rd_addr_out) & ~mask_w) | (($past(rd_addr_out) + 1'b1) &
        mask_w)) : $past(rd_addr_out) + 1'b1))
        else $error("burst step address wrong");
endmodule // bwc_top_chk

bind bwc_top bwc_top_chk #(.ADDR_W(ADDR_W)) i_bwc_top_chk (.ref_clk, .rst_b,
    .sw_reset, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_data,
    .ecc_lookup, .ecc_unit_addr, .ecc_code_err, .ecc_data_err, .ecc_off, .rd_start, .rd_kind,
    .rd_target, .rd_addr, .rd_next, .rd_addr_out, .rd_wrapping, .drive_strength_sel, .wrap_off,
    .wrap_length_live);

`default_nettype wire

/* bwc_wrap_gen.sv */
`timescale 1ns/100ps
`default_nettype none
`include "bwc_map.svh"

// Burst address generator: sequential or wrapped inside an aligned block.
module bwc_wrap_gen #(
    parameter int ADDR_W = 24
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    bwc_wrap_if.gen   wrp
);
    import bwc_pkg::*;

    localparam int OW = `BWC_WRAP_OFS_W;

    logic [ADDR_W-1:0] addr_q, addr_d;  // Current byte address.
    logic              wrap_q, wrap_d;  // Burst wraps.
    logic [1:0]        len_q, len_d;    // Latched length code.
    logic [ADDR_W-1:0] inc;             // Address plus one.
    logic [OW-1:0]     mask;            // Offset bits inside the block.
    logic [ADDR_W-1:0] stepped;         // Address after one step.

    // Block offset mask for a length code: 8, 16, 32 or 64 bytes.
    function automatic logic [OW-1:0] len_mask(input logic [1:0] code);
        return OW'((7'h08 << code) - 7'h01);
    endfunction

    assign inc  = addr_q + ADDR_W'(1);
    assign mask = len_mask(len_q);

    // Offset bits inside the block roll over; outer bits hold when wrapping.
    for (genvar i = 0; i < ADDR_W; i++) begin : g_bit
        if (i < OW) begin : g_low
            assign stepped[i] = (!wrap_q || mask[i]) ? inc[i] : addr_q[i]; // R15
        end else begin : g_high
            assign stepped[i] = wrap_q ? addr_q[i] : inc[i]; // R15
        end
    end

    // Next burst state: a start reloads, an advance steps.
    always_comb begin
        addr_d = addr_q;
        wrap_d = wrap_q;
        len_d  = len_q;
        if (wrp.start) begin
            addr_d = wrp.base;
            wrap_d = wrp.enable;
            len_d  = wrp.len_code;
        end else if (wrp.advance) begin
            addr_d = stepped;
        end
    end

    // Registers the burst state.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            addr_q <= '0;
            wrap_q <= 1'b0;
            len_q  <= 2'h0;
        end else begin
            addr_q <= addr_d;
            wrap_q <= wrap_d;
            len_q  <= len_d;
        end
    end

    assign wrp.addr     = addr_q;
    assign wrp.wrapping = wrap_q;
endmodule // bwc_wrap_gen

`default_nettype wire

/* bwc_wrap_if.sv */
`timescale 1ns/100ps
`default_nettype none

// Carries burst control from the register logic to the address generator.
interface bwc_wrap_if #(
    parameter int ADDR_W = 24
);
    logic              start;     // Opens a burst at base.
    logic [ADDR_W-1:0] base;      // First byte address of the burst.
    logic              enable;    // Burst wraps inside its block.
    logic [1:0]        len_code;  // Wrap length code.
    logic              advance;   // Steps to the next byte.
    logic [ADDR_W-1:0] addr;      // Current byte address.
    logic              wrapping;  // Current burst wraps.

    // The register side drives the controls.
    modport ctrl (output start, output base, output enable, output len_code,
                  output advance, input addr, input wrapping);
    // The generator side drives the address.
    modport gen (input start, input base, input enable, input len_code,
                 input advance, output addr, output wrapping);
endinterface

`default_nettype wire
